// [core/irma_top.sv]
// Purpose: Two-wire slave engine with map selection and subaddress auto-increment
// Assumes: Engine runs on the falling serial clock edge; data sampled there
// Notes:   Register contents outside the page and map-address registers
//          are reached through the acc_* port in the serial clock domain

`timescale 1ns/100ps
`default_nettype none

module irma_top
  import irma_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  input  wire logic  scl_clk,
  input  wire logic  serial_data_pin_i,
  output logic       serial_data_pin_o,
  output logic       serial_data_pin_oe,
  input  wire logic  address_strap_pin,
  output logic       acc_wr,
  output irma_map_t  acc_map,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  input  wire logic [7:0] acc_rdata,
  output logic [1:0] map_page_select,
  output logic [6:0] postproc_bus_addr,
  output logic [6:0] serial_out_bus_addr
);

  // ************************************************************
  // Core domain: reset flop feeding the link domain
  // ************************************************************
  typedef struct packed {
    logic link_rst;
  } irma_core_state_t;

  irma_core_state_t core_q;
  irma_core_state_t core_d;

  always_comb
  begin
    core_d          = core_q;
    core_d.link_rst = sys_rst;
  end

  always_ff @(posedge core_clk)
  begin
    core_q <= core_d;
  end

  // ************************************************************
  // Link domain state
  // ************************************************************
  typedef struct packed {
    irma_state_t state;
    logic [2:0]  cnt;
    logic [7:0]  shreg;
    logic        rw;
    irma_map_t   map;
    logic [7:0]  sub;
    logic        over;
    logic [1:0]  page;
    logic [6:0]  pp_addr;
    logic [6:0]  so_addr;
    logic        oe;
    logic        tog;
    logic        wr;
    logic [7:0]  wdata;
    logic        strap_meta;
    logic        strap_sync;
  } irma_link_state_t;

  localparam irma_link_state_t LINK_RESET = '{
    state:      ST_IDLE,
    cnt:        3'h0,
    shreg:      8'h00,
    rw:         1'b0,
    map:        MAP_USER,
    sub:        8'h00,
    over:       1'b0,
    page:       PAGE_RESET,
    pp_addr:    MAP_ADDR_RESET,
    so_addr:    MAP_ADDR_RESET,
    oe:         1'b0,
    tog:        1'b0,
    wr:         1'b0,
    wdata:      8'h00,
    strap_meta: 1'b0,
    strap_sync: 1'b0
  };

  irma_link_state_t link_q;
  irma_link_state_t link_d;
  logic             sda_high_q;

  // ************************************************************
  // Decoding functions
  // ************************************************************
  function automatic logic [7:0] map_top(input irma_map_t m);
    logic [7:0] t;
    t = TOP_USER;
    case (m)
      MAP_INTR:  t = TOP_INTR;
      MAP_USER2: t = TOP_USER2;
      MAP_PP:    t = TOP_PP;
      MAP_SO:    t = TOP_SO;
      default:   t = TOP_USER;
    endcase
    return t;
  endfunction : map_top

  function automatic logic in_main(input irma_map_t m);
    return (m == MAP_USER) || (m == MAP_INTR) || (m == MAP_USER2);
  endfunction : in_main

  function automatic irma_map_t page_map(input logic [1:0] p);
    irma_map_t m;
    m = MAP_USER;
    if (p == 2'h1)
    begin
      m = MAP_INTR;
    end
    else if (p == 2'h2)
    begin
      m = MAP_USER2;
    end
    return m;
  endfunction : page_map

  // ************************************************************
  // Start/stop sampling: data level while clock is high
  // ************************************************************
  always_ff @(posedge scl_clk or posedge core_q.link_rst)
  begin
    if (core_q.link_rst)
    begin
      sda_high_q <= 1'b1;
    end
    else
    begin
      sda_high_q <= serial_data_pin_i;
    end
  end

  // ************************************************************
  // Link engine
  // ************************************************************
  logic       start_seen;
  logic       stop_seen;
  logic [7:0] byte_in;
  logic [6:0] main_addr;
  logic       hit;
  irma_map_t  hit_map;
  logic       sub_ok;
  logic [7:0] rd_byte;

  always_comb
  begin
    start_seen = sda_high_q && !serial_data_pin_i;
    stop_seen  = !sda_high_q && serial_data_pin_i;
    byte_in    = {link_q.shreg[6:0], serial_data_pin_i};

    main_addr            = MAIN_ADDR_BASE;
    main_addr[STRAP_BIT] = link_q.strap_sync;

    hit     = 1'b0;
    hit_map = MAP_USER;
    if (byte_in[7:1] == main_addr)
    begin
      hit     = 1'b1;
      hit_map = page_map(link_q.page);
    end
    else if ((link_q.pp_addr != MAP_ADDR_RESET) && (byte_in[7:1] == link_q.pp_addr))
    begin
      hit     = 1'b1;
      hit_map = MAP_PP;
    end
    else if ((link_q.so_addr != MAP_ADDR_RESET) && (byte_in[7:1] == link_q.so_addr))
    begin
      hit     = 1'b1;
      hit_map = MAP_SO;
    end

    sub_ok = (byte_in <= map_top(link_q.map));

    rd_byte = acc_rdata;
    if (in_main(link_q.map) && (link_q.sub == SUB_PAGE_SEL))
    begin
      rd_byte                    = 8'h00;
      rd_byte[PAGE_MSB:PAGE_LSB] = link_q.page;
    end
    else if ((link_q.map == MAP_USER) && (link_q.sub == SUB_PP_ADDR))
    begin
      rd_byte = {link_q.pp_addr, 1'b0};
    end
    else if ((link_q.map == MAP_USER) && (link_q.sub == SUB_SO_ADDR))
    begin
      rd_byte = {link_q.so_addr, 1'b0};
    end

    link_d            = link_q;
    link_d.wr         = 1'b0;
    link_d.strap_meta = address_strap_pin;
    link_d.strap_sync = link_q.strap_meta;

    if (start_seen)
    begin
      link_d.state = ST_ADDR;
      link_d.cnt   = 3'h0;
      link_d.oe    = 1'b0;
    end
    else if (stop_seen)
    begin
      link_d.state = ST_IDLE;
      link_d.oe    = 1'b0;
    end
    else
    begin
      case (link_q.state)
        ST_IDLE:
        begin
          link_d.oe = 1'b0;
        end
        ST_ADDR:
        begin
          link_d.shreg = byte_in;
          link_d.cnt   = link_q.cnt + 3'h1;
          if (link_q.cnt == LAST_BIT)
          begin
            if (hit)
            begin
              link_d.map   = hit_map;
              link_d.rw    = byte_in[0];
              link_d.oe    = 1'b1;
              link_d.state = ST_ADDR_ACK;
            end
            else
            begin
              link_d.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          link_d.cnt = 3'h0;
          if (link_q.rw)
          begin
            link_d.shreg = rd_byte;
            link_d.oe    = !rd_byte[7];
            link_d.state = ST_RDATA;
          end
          else
          begin
            link_d.oe    = 1'b0;
            link_d.state = ST_SUB;
          end
        end
        ST_SUB:
        begin
          link_d.shreg = byte_in;
          link_d.cnt   = link_q.cnt + 3'h1;
          if (link_q.cnt == LAST_BIT)
          begin
            if (sub_ok)
            begin
              link_d.sub   = byte_in;
              link_d.over  = 1'b0;
              link_d.oe    = 1'b1;
              link_d.state = ST_SUB_ACK;
            end
            else
            begin
              link_d.state = ST_IDLE;
            end
          end
        end
        ST_SUB_ACK:
        begin
          link_d.oe    = 1'b0;
          link_d.cnt   = 3'h0;
          link_d.state = ST_WDATA;
        end
        ST_WDATA:
        begin
          link_d.shreg = byte_in;
          link_d.cnt   = link_q.cnt + 3'h1;
          if (link_q.cnt == LAST_BIT)
          begin
            if (link_q.over)
            begin
              link_d.state = ST_IDLE;
            end
            else
            begin
              link_d.wr    = 1'b1;
              link_d.wdata = byte_in;
              link_d.oe    = 1'b1;
              link_d.state = ST_WDATA_ACK;
              if (in_main(link_q.map) && (link_q.sub == SUB_PAGE_SEL))
              begin
                link_d.page = byte_in[PAGE_MSB:PAGE_LSB];
                link_d.tog  = !link_q.tog;
              end
              else if ((link_q.map == MAP_USER) && (link_q.sub == SUB_PP_ADDR))
              begin
                link_d.pp_addr = byte_in[7:1];
                link_d.tog     = !link_q.tog;
              end
              else if ((link_q.map == MAP_USER) && (link_q.sub == SUB_SO_ADDR))
              begin
                link_d.so_addr = byte_in[7:1];
                link_d.tog     = !link_q.tog;
              end
              if (link_q.sub == map_top(link_q.map))
              begin
                link_d.over = 1'b1;
              end
              else
              begin
                link_d.sub = link_q.sub + 8'h01;
              end
            end
          end
        end
        ST_WDATA_ACK:
        begin
          link_d.oe    = 1'b0;
          link_d.cnt   = 3'h0;
          link_d.state = ST_WDATA;
        end
        ST_RDATA:
        begin
          if (link_q.cnt == LAST_BIT)
          begin
            link_d.oe    = 1'b0;
            link_d.state = ST_RD_ACK;
            if (link_q.sub != map_top(link_q.map))
            begin
              link_d.sub = link_q.sub + 8'h01;
            end
          end
          else
          begin
            link_d.cnt   = link_q.cnt + 3'h1;
            link_d.shreg = {link_q.shreg[6:0], 1'b0};
            link_d.oe    = !link_q.shreg[6];
          end
        end
        ST_RD_ACK:
        begin
          link_d.cnt = 3'h0;
          if (serial_data_pin_i)
          begin
            link_d.state = ST_IDLE;
          end
          else
          begin
            link_d.shreg = rd_byte;
            link_d.oe    = !rd_byte[7];
            link_d.state = ST_RDATA;
          end
        end
        default:
        begin
          link_d.state = ST_IDLE;
          link_d.oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge scl_clk or posedge core_q.link_rst)
  begin
    if (core_q.link_rst)
    begin
      link_q <= LINK_RESET;
    end
    else
    begin
      link_q <= link_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign serial_data_pin_o  = 1'b0;
  assign serial_data_pin_oe = link_q.oe;
  assign acc_wr             = link_q.wr;
  assign acc_map            = link_q.map;
  assign acc_addr           = (link_q.wr && !link_q.over) ? link_q.sub - 8'h01 : link_q.sub;
  assign acc_wdata          = link_q.wdata;

  irma_cfg_if cfg_bus ();

  assign cfg_bus.upd_tog = link_q.tog;
  assign cfg_bus.page    = link_q.page;
  assign cfg_bus.pp_addr = link_q.pp_addr;
  assign cfg_bus.so_addr = link_q.so_addr;

  irma_cfg_sync u_cfg_sync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .cfg       (cfg_bus.core_dst),
    .page_o    (map_page_select),
    .pp_addr_o (postproc_bus_addr),
    .so_addr_o (serial_out_bus_addr)
  );

endmodule : irma_top

`default_nettype wire

// [core/irma_pkg.sv]
// Purpose: Shared constants and types for the two-wire register map access block
// Assumes: Serial clock is the link clock; subaddress storage outside the
//          page and map-address registers lives in user logic

package irma_pkg;

  // ************************************************************
  // Subaddresses of local registers
  // ************************************************************
  localparam logic [7:0] SUB_PAGE_SEL   = 8'h0E;
  localparam logic [7:0] SUB_PP_ADDR    = 8'hFD;
  localparam logic [7:0] SUB_SO_ADDR    = 8'hFE;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int         PAGE_LSB       = 5;
  localparam int         PAGE_MSB       = 6;
  localparam logic [1:0] PAGE_RESET     = 2'h0;
  localparam logic [6:0] MAP_ADDR_RESET = 7'h00;

  // ************************************************************
  // Bus addresses (7-bit form)
  // ************************************************************
  localparam logic [6:0] MAIN_ADDR_BASE = 7'h20;
  localparam int         STRAP_BIT      = 0;

  // ************************************************************
  // Highest subaddress of each map
  // ************************************************************
  localparam logic [7:0] TOP_USER       = 8'hFE;
  localparam logic [7:0] TOP_INTR       = 8'hFF;
  localparam logic [7:0] TOP_USER2      = 8'hFF;
  localparam logic [7:0] TOP_PP         = 8'hFF;
  localparam logic [7:0] TOP_SO         = 8'hFF;

  localparam logic [2:0] LAST_BIT       = 3'h7;

  typedef enum logic [2:0] {
    MAP_USER,
    MAP_INTR,
    MAP_USER2,
    MAP_PP,
    MAP_SO
  } irma_map_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_SUB,
    ST_SUB_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RD_ACK
  } irma_state_t;

endpackage : irma_pkg

// [core/irma_cfg_if.sv]
// Purpose: Carries the configuration registers from link domain to core domain
// Assumes: Bus fields change only in the link cycle that flips the toggle
// Notes:   Toggle marks each update

`timescale 1ns/100ps
`default_nettype none

interface irma_cfg_if;
  logic       upd_tog;
  logic [1:0] page;
  logic [6:0] pp_addr;
  logic [6:0] so_addr;

  modport link_src (output upd_tog, output page, output pp_addr, output so_addr);
  modport core_dst (input upd_tog, input page, input pp_addr, input so_addr);
endinterface : irma_cfg_if

`default_nettype wire

// [core/irma_cfg_sync.sv]
// Purpose: Brings configuration registers into the core clock domain
// Assumes: Updates spaced by a whole serial byte at least
// Notes:   Bus captured once the synchronised toggle has moved

`timescale 1ns/100ps
`default_nettype none

module irma_cfg_sync
  import irma_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    sys_rst,
  irma_cfg_if.core_dst cfg,
  output logic [1:0]   page_o,
  output logic [6:0]   pp_addr_o,
  output logic [6:0]   so_addr_o
);

  typedef struct packed {
    logic       tog_meta;
    logic       tog_sync;
    logic       tog_seen;
    logic [1:0] page;
    logic [6:0] pp_addr;
    logic [6:0] so_addr;
  } irma_sync_state_t;

  irma_sync_state_t sync_q;
  irma_sync_state_t sync_d;

  always_comb
  begin
    sync_d          = sync_q;
    sync_d.tog_meta = cfg.upd_tog;
    sync_d.tog_sync = sync_q.tog_meta;
    sync_d.tog_seen = sync_q.tog_sync;
    if (sync_q.tog_sync != sync_q.tog_seen)
    begin
      sync_d.page    = cfg.page;
      sync_d.pp_addr = cfg.pp_addr;
      sync_d.so_addr = cfg.so_addr;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync_q <= '{1'b0, 1'b0, 1'b0, PAGE_RESET, MAP_ADDR_RESET, MAP_ADDR_RESET};
    end
    else
    begin
      sync_q <= sync_d;
    end
  end

  assign page_o    = sync_q.page;
  assign pp_addr_o = sync_q.pp_addr;
  assign so_addr_o = sync_q.so_addr;

endmodule : irma_cfg_sync

`default_nettype wire

// [verif/irma_checker.sv]
// Purpose: Port checks for the register map access block
// Assumes: Engine moves on falling serial clock edges
// Notes:   Bound to irma_top below
`timescale 1ns/100ps
`default_nettype none
module irma_checker
  import irma_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       scl_clk,
  input wire logic       serial_data_pin_i,
  input wire logic       serial_data_pin_o,
  input wire logic       serial_data_pin_oe,
  input wire logic       address_strap_pin,
  input wire logic       acc_wr,
  input wire irma_map_t  acc_map,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic [1:0] map_page_select,
  input wire logic [6:0] postproc_bus_addr,
  input wire logic [6:0] serial_out_bus_addr
);
  // ****
  // Run of pulled-low bits
  // ****
  logic [3:0] run_q;
  logic [3:0] run_d;
  always_comb run_d = serial_data_pin_oe ? run_q + 4'h1 : 4'h0;
  always_ff @(negedge scl_clk or posedge sys_rst)
    if (sys_rst)
      run_q <= 4'h0;
    else
      run_q <= run_d;

  AST_RST_IDLE: assert property (@(posedge core_clk)
    sys_rst ##1 sys_rst |-> !serial_data_pin_oe && !acc_wr) else $error("busy in reset");
  AST_RST_CFG: assert property (@(posedge core_clk) sys_rst |=>
    map_page_select == PAGE_RESET && postproc_bus_addr == MAP_ADDR_RESET
    && serial_out_bus_addr == MAP_ADDR_RESET) else $error("config not cleared");
  AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (sys_rst)
    serial_data_pin_o == 1'b0) else $error("data driven high");
  AST_WR_ACK: assert property (@(negedge scl_clk) disable iff (sys_rst)
    $rose(acc_wr) |-> $rose(serial_data_pin_oe)) else $error("write without ack");
  AST_WR_ONE: assert property (@(negedge scl_clk) disable iff (sys_rst)
    $rose(acc_wr) |=> !acc_wr && !serial_data_pin_oe) else $error("write too long");
  AST_WR_GAP: assert property (@(negedge scl_clk) disable iff (sys_rst)
    $rose(acc_wr) |=> (!acc_wr) [*8]) else $error("writes too close");
  AST_INC: assert property (@(negedge scl_clk) disable iff (sys_rst)
    acc_wr ##9 acc_wr |-> acc_addr == $past(acc_addr, 9) + 8'h01)
    else $error("no increment");
  AST_ACK_LEN: assert property (@(negedge scl_clk) disable iff (sys_rst)
    run_q <= 4'h9) else $error("line held too long");

  cover property (@(negedge scl_clk) acc_wr && acc_map == MAP_PP);
  cover property (@(negedge scl_clk) acc_wr ##9 acc_wr);
  cover property (@(posedge core_clk) map_page_select == 2'h2);
endmodule : irma_checker

bind irma_top irma_checker u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .scl_clk(scl_clk),
  .serial_data_pin_i(serial_data_pin_i), .serial_data_pin_o(serial_data_pin_o),
  .serial_data_pin_oe(serial_data_pin_oe), .address_strap_pin(address_strap_pin),
  .acc_wr(acc_wr), .acc_map(acc_map), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
  .acc_rdata(acc_rdata), .map_page_select(map_page_select),
  .postproc_bus_addr(postproc_bus_addr), .serial_out_bus_addr(serial_out_bus_addr)
);
`default_nettype wire

// [verif/irma_master.sv]
// Purpose: Two-wire bus master model
// Assumes: Serial clock parked low between frames
// Notes:   Six ns bit; pull high holds the data line low
`timescale 1ns/100ps
`default_nettype none
module irma_master (
  output logic        scl,
  output logic        pull,
  input  wire logic   sda,
  output logic [8:0]  res_val,
  output logic [15:0] res_cnt
);
  initial
  begin
    scl = 1'b0;
    pull = 1'b0;
    res_val = 9'h000;
    res_cnt = 16'h0000;
  end
  task automatic bit_x(input logic b, output logic s);
    #1 pull = !b;
    #2 scl = 1'b1;
    #1 s = sda;
    #2 scl = 1'b0;
  endtask : bit_x
  // Start for p low, stop for p high, one per high period
  task automatic cond(input logic p);
    #1 pull = p;
    #2 scl = 1'b1;
    #1.5 pull = !p;
    #1.5 scl = 1'b0;
  endtask : cond
  task automatic send(input logic [7:0] d, input int n, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--)
      bit_x(d[i], s);
    if (n == 8)
    begin
      bit_x(1'b1, s);
      ack = !s;
      res_val = {ack, 8'h00};
      res_cnt = res_cnt + 16'h0001;
    end
  endtask : send
  task automatic recv(input logic mack);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(!mack, s);
    res_val = {1'b1, d};
    res_cnt = res_cnt + 16'h0001;
  endtask : recv
endmodule : irma_master
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the register map access block
// Assumes: Master model drives the serial clock only within frames
// Notes:   Byte results queued and matched by a monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import irma_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        strap = 1'b0;
  logic        scl;
  logic        pull;
  logic        sda;
  logic        oe;
  logic        acc_wr;
  irma_map_t   acc_map;
  logic [7:0]  acc_addr;
  logic [7:0]  acc_wdata;
  logic [7:0]  acc_rdata;
  logic [1:0]  page;
  logic [6:0]  pp_a;
  logic [6:0]  so_a;
  logic [8:0]  res_val;
  logic [15:0] res_cnt;
  logic [8:0]  expq[$];
  logic [18:0] lw = 19'h00000;
  logic [7:0]  ma;
  int          nwr = 0;
  int          num_errors = 0;
  int          n_tests = 0;

  always #25 core_clk = !core_clk;
  assign sda = !(oe | pull);
  assign acc_rdata = acc_addr ^ {acc_map, 5'h0A};

  irma_top dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_clk(scl),
    .serial_data_pin_i(sda), .serial_data_pin_o(), .serial_data_pin_oe(oe),
    .address_strap_pin(strap), .acc_wr(acc_wr), .acc_map(acc_map),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .map_page_select(page), .postproc_bus_addr(pp_a), .serial_out_bus_addr(so_a)
  );
  irma_master mst (
    .scl(scl), .pull(pull), .sda(sda), .res_val(res_val), .res_cnt(res_cnt)
  );

  // ****
  // Checking
  // ****
  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] s);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  always @(res_cnt)
    if (res_cnt != 16'h0000)
      chk("byte", (expq.size() != 0) ? 19'(expq.pop_front()) : 19'h7FFFF, 19'(res_val));
  always @(posedge scl)
    if (acc_wr === 1'b1)
    begin
      lw <= {acc_map, acc_addr, acc_wdata};
      nwr <= nwr + 1;
    end
  function automatic logic [7:0] rdm(input irma_map_t mp, input logic [7:0] a);
    return a ^ {mp, 5'h0A};
  endfunction : rdm

  // ****
  // Stimulus
  // ****
  task automatic wb(input logic [7:0] d, input logic a);
    logic k;
    expq.push_back({a, 8'h00});
    mst.send(d, 8, k);
  endtask : wb
  task automatic wr(input logic [7:0] ad, input logic [7:0] sb, input logic [7:0] d, input int n);
    mst.cond(1'b0);
    wb(ad, 1'b1);
    wb(sb, 1'b1);
    for (int i = 0; i < n; i++)
      wb(d + 8'(i), 1'b1);
    mst.cond(1'b1);
  endtask : wr
  task automatic probe(input logic [7:0] ad, input logic a);
    mst.cond(1'b0);
    wb(ad, a);
    mst.cond(1'b1);
  endtask : probe
  task automatic do_rst();
    @(negedge core_clk) sys_rst = 1'b1;
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : do_rst
  task automatic settle();
    repeat (8) @(negedge core_clk);
  endtask : settle

  initial
  begin
    #100000;
    num_errors++;
    summarize();
  end

  initial
  begin
    logic [7:0] d;
    logic       k;
    int         n;
    d = 8'($urandom(32'h48949ABE));
    do_rst();
    chk("page", 19'h0, 19'(page));
    chk("pp", 19'h0, 19'(pp_a));
    chk("so", 19'h0, 19'(so_a));
    for (int s = 0; s < 2; s++)
    begin
      @(negedge core_clk) strap = s[0];
      ma = 8'h40 | {6'h00, s[0], 1'b0};
      probe(ma ^ 8'h02, 1'b0);
      wr(ma, 8'h10, d, 1);
      chk("log", {MAP_USER, 8'h10, d}, lw);
    end
    for (int p = 0; p < 3; p++)
    begin
      d = 8'($urandom);
      wr(ma, SUB_PAGE_SEL, 8'(p << PAGE_LSB), 1);
      wr(ma, 8'h10, d, 1);
      chk("map", {3'(p), 8'h10, d}, lw);
      settle();
      chk("page", 19'(p), 19'(page));
    end
    wr(ma, 8'hFE, 8'h00, 0);
    mst.cond(1'b0);
    wb(ma | 8'h01, 1'b1);
    expq.push_back({1'b1, rdm(MAP_USER2, 8'hFE)});
    mst.recv(1'b1);
    expq.push_back({1'b1, rdm(MAP_USER2, 8'hFF)});
    mst.recv(1'b1);
    expq.push_back({1'b1, rdm(MAP_USER2, 8'hFF)});
    mst.recv(1'b0);
    mst.cond(1'b1);
    n = nwr;
    mst.cond(1'b0);
    wb(ma, 1'b1);
    wb(8'hFF, 1'b1);
    wb(d, 1'b1);
    wb(d, 1'b0);
    wb(d, 1'b0);
    mst.cond(1'b1);
    chk("count", 19'(n + 1), 19'(nwr));
    chk("top", {MAP_USER2, 8'hFF, d}, lw);
    wr(ma, SUB_PAGE_SEL, 8'h00, 1);
    mst.cond(1'b0);
    wb(ma, 1'b1);
    wb(8'hFF, 1'b0);
    wb(d, 1'b0);
    mst.cond(1'b1);
    n = nwr;
    wr(ma, 8'h20, d, 3);
    chk("burst", {MAP_USER, 8'h22, d + 8'h02}, lw);
    chk("count", 19'(n + 3), 19'(nwr));
    mst.cond(1'b0);
    wb(ma, 1'b1);
    wb(8'h30, 1'b1);
    mst.send(d, 4, k);
    wr(ma, 8'h31, d, 1);
    chk("abort", {MAP_USER, 8'h31, d}, lw);
    chk("count", 19'(n + 4), 19'(nwr));
    probe(8'h84, 1'b0);
    probe(8'h88, 1'b0);
    wr(ma, SUB_PP_ADDR, 8'h84, 1);
    settle();
    wr(ma, SUB_SO_ADDR, 8'h88, 1);
    settle();
    chk("pp", 19'h42, 19'(pp_a));
    chk("so", 19'h44, 19'(so_a));
    wr(ma, SUB_PAGE_SEL, 8'h40, 1);
    wr(ma, SUB_PAGE_SEL, 8'h00, 0);
    mst.cond(1'b0);
    wb(ma | 8'h01, 1'b1);
    expq.push_back({1'b1, 8'h40});
    mst.recv(1'b0);
    mst.cond(1'b1);
    @(negedge core_clk) strap = !strap;
    wr(8'h84, 8'h10, d, 1);
    chk("pp map", {MAP_PP, 8'h10, d}, lw);
    wr(8'h88, 8'h11, d, 1);
    chk("so map", {MAP_SO, 8'h11, d}, lw);
    mst.cond(1'b0);
    wb(8'h84, 1'b1);
    mst.send(d, 4, k);
    do_rst();
    chk("page", 19'h0, 19'(page));
    chk("pp", 19'h0, 19'(pp_a));
    chk("so", 19'h0, 19'(so_a));
    probe(8'h88, 1'b0);
    probe(8'h84, 1'b0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
